// ---- inc/adccev_pkg.sv ----
// package for the converter completion-event block
// assumes one peripheral clock and an active-low asynchronous reset
package adccev_pkg;
   // channel groups: lower bank 0..15, upper bank 40..47
   localparam int LOW_CHANS = 16;
   localparam int UP_CHANS  = 8;
   localparam int UP_BASE   = 40;
   // reset values of flags, enables, routes
   localparam logic [LOW_CHANS-1:0] LOW_RST = 16'h0000;
   localparam logic [UP_CHANS-1:0]  UP_RST  = 8'h00;
   // bit of the lower bank that may be routed to the second controller
   localparam int SEC_DMA_CHAN = 0;
   // completion events from the conversion sequencer
   typedef struct packed {
      logic                 scan_done;  // scan conversion finished
      logic [LOW_CHANS-1:0] low_done;   // per-channel interrupt conversion done
      logic [UP_CHANS-1:0]  up_done;    // upper channel interrupt conversion done
   } adccev_evt_t;
   // software clear strobes for each flag
   typedef struct packed {
      logic                 scan;
      logic [LOW_CHANS-1:0] low;
      logic [UP_CHANS-1:0]  up;
   } adccev_clr_t;
endpackage

// ---- logic/adccev_flag.sv ----
// one sticky completion flag with its request routing
// assumes set, clear and acknowledge strobes are synchronous one-cycle pulses
module adccev_flag
(
   input  wire logic i_clock,    // peripheral clock
   input  wire logic i_rstn,     // asynchronous reset, active low
   input  wire logic i_set,      // conversion completed
   input  wire logic i_sw_clr,   // software clear
   input  wire logic i_dma_ack,  // dma transfer performed
   input  wire logic i_enable,   // request enable
   input  wire logic i_to_dma,   // route request to dma instead of cpu
   output logic      o_flag,     // flag state
   output logic      o_cpu_irq,  // level request to cpu
   output logic      o_dma_req   // level request to dma
);
   logic flag_reg;   // sticky flag
   logic flag_next;  // next flag value
   logic cpu_reg;    // registered cpu request
   logic dma_reg;    // registered dma request
   logic clr_w;      // any clear source this cycle

   // R4 R9 cpu delivery never clears
   // R3 R7 R8 routed dma transfer clears
   // an ack on an unrouted flag is ignored so a stray transfer loses nothing
   assign clr_w = i_sw_clr | (i_dma_ack & i_to_dma);
   // set wins over a coincident clear so no completion is lost
   assign flag_next = i_set | (flag_reg & ~clr_w);

   // flag and request registers
   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         flag_reg <= 1'b0;
         cpu_reg  <= 1'b0;
         dma_reg  <= 1'b0;
      end
      else
      begin
         flag_reg <= flag_next;
         // R2 R12 routed request skips cpu
         cpu_reg  <= flag_next & i_enable & ~i_to_dma;
         dma_reg  <= flag_next & i_enable & i_to_dma;
      end
   end

   assign o_flag    = flag_reg;
   assign o_cpu_irq = cpu_reg;
   assign o_dma_req = dma_reg;
endmodule

// ---- logic/adccev_top.sv ----
// completion flags and interrupt or dma requests of the a/d converter
// assumes the sequencer pulses completion events; dma acks are one-cycle pulses
// Functional notes
// R1 - scan-end request gated by its enable bit
// R2 - scan-end routed to dma: no cpu request
// R3 - general dma transfer clears scan-end flag
// R4 - cpu request leaves scan-end flag unchanged
// R5 - per-channel requests for 0-15 and 40-47
// R6 - one enable bit per channel request
// R7 - upper channel dma transfer clears its flag
// R8 - second dma transfer clears channel 0 flag
// R9 - cpu request leaves channel flags unchanged
// R10 - scan done sets flag, clears scan active
// R11 - channel done sets flag, clears active
// R12 - cpu request is level of flag and enable
module adccev_top
#(
   parameter int LOW_N = adccev_pkg::LOW_CHANS,  // lower bank channels
   parameter int UP_N  = adccev_pkg::UP_CHANS    // upper bank channels
)
(
   input  wire logic                  i_clock,           // 10 mhz clock
   input  wire logic                  i_rstn,            // async reset, active low
   input  wire adccev_pkg::adccev_evt_t i_evt,           // completion events
   input  wire logic                  i_scan_start,      // scan conversion begins
   input  wire logic                  i_intconv_start,   // interrupt conversion begins
   input  wire adccev_pkg::adccev_clr_t i_sw_clr,        // software flag clears
   input  wire logic                  i_scan_end_irq_enable,              // scan enable
   input  wire logic [LOW_N-1:0]      i_chan_conv_end_irq_enable,         // low enables
   input  wire logic [UP_N-1:0]       i_upper_chan_conv_end_irq_enable,   // up enables
   input  wire logic                  i_scan_to_dma,     // route scan-end to general dma
   input  wire logic [UP_N-1:0]       i_up_to_dma,       // route upper to general dma
   input  wire logic                  i_chan0_to_dma,    // route channel 0 to second dma
   input  wire logic                  i_scan_dma_ack,    // general dma did scan transfer
   input  wire logic [UP_N-1:0]       i_up_dma_ack,      // general dma did upper transfer
   input  wire logic                  i_chan0_dma_ack,   // second dma did transfer
   output logic                       o_scan_end_flag,   // scan-end flag
   output logic [LOW_N-1:0]           o_chan_conv_end_flag,        // low flags
   output logic [UP_N-1:0]            o_upper_chan_conv_end_flag,  // upper flags
   output logic                       o_scan_end_irq,    // cpu request, scan end
   output logic [LOW_N-1:0]           o_chan_conv_end_irq,         // cpu low requests
   output logic [UP_N-1:0]            o_upper_chan_conv_end_irq,   // cpu upper requests
   output logic                       o_scan_dma_req,    // general dma request, scan
   output logic [UP_N-1:0]            o_up_dma_req,      // general dma request, upper
   output logic                       o_chan0_dma_req,   // second dma request
   output logic                       o_scan_active_indicator,     // scan running
   output logic                       o_intconv_active_indicator   // intconv running
);
   import adccev_pkg::*;

   logic [LOW_N-1:0] low_dma_w;   // per low channel dma route
   logic [LOW_N-1:0] low_ack_w;   // per low channel dma ack
   logic [LOW_N-1:0] low_dreq_w;  // per low channel dma request
   logic             scan_act_reg;  // scan active state
   logic             int_act_reg;   // interrupt conversion active state
   logic             any_low_w;     // any lower channel completed
   logic             any_up_w;      // any upper channel completed

   // R1 scan-end flag and gated request; R2/R3/R4 handled by routing
   adccev_flag u_scan
   (
      .i_clock   (i_clock),
      .i_rstn    (i_rstn),
      .i_set     (i_evt.scan_done),
      .i_sw_clr  (i_sw_clr.scan),
      .i_dma_ack (i_scan_dma_ack),
      .i_enable  (i_scan_end_irq_enable),
      .i_to_dma  (i_scan_to_dma),
      .o_flag    (o_scan_end_flag),
      .o_cpu_irq (o_scan_end_irq),
      .o_dma_req (o_scan_dma_req)
   );

   // only channel 0 of the lower bank reaches the second controller
   generate
      for (genvar g = 0; g < LOW_N; g++)
      begin : g_low_route
         assign low_dma_w[g] = (g == SEC_DMA_CHAN) ? i_chan0_to_dma : 1'b0;
         assign low_ack_w[g] = (g == SEC_DMA_CHAN) ? i_chan0_dma_ack : 1'b0;
      end
   endgenerate

   // R5 R6 one flag cell per lower channel with its own enable
   generate
      for (genvar c = 0; c < LOW_N; c++)
      begin : g_low
         // R8 channel 0 cleared by second dma transfer
         adccev_flag u_f
         (
            .i_clock   (i_clock),
            .i_rstn    (i_rstn),
            .i_set     (i_evt.low_done[c]),
            .i_sw_clr  (i_sw_clr.low[c]),
            .i_dma_ack (low_ack_w[c]),
            .i_enable  (i_chan_conv_end_irq_enable[c]),
            .i_to_dma  (low_dma_w[c]),
            .o_flag    (o_chan_conv_end_flag[c]),
            .o_cpu_irq (o_chan_conv_end_irq[c]),
            .o_dma_req (low_dreq_w[c])
         );
      end
   endgenerate

   assign o_chan0_dma_req = low_dreq_w[SEC_DMA_CHAN];

   // R5 R6 upper channels 40..47
   generate
      for (genvar u = 0; u < UP_N; u++)
      begin : g_up
         // R7 upper flag cleared by general dma transfer
         adccev_flag u_f
         (
            .i_clock   (i_clock),
            .i_rstn    (i_rstn),
            .i_set     (i_evt.up_done[u]),
            .i_sw_clr  (i_sw_clr.up[u]),
            .i_dma_ack (i_up_dma_ack[u]),
            .i_enable  (i_upper_chan_conv_end_irq_enable[u]),
            .i_to_dma  (i_up_to_dma[u]),
            .o_flag    (o_upper_chan_conv_end_flag[u]),
            .o_cpu_irq (o_upper_chan_conv_end_irq[u]),
            .o_dma_req (o_up_dma_req[u])
         );
      end
   endgenerate

   assign any_low_w = |i_evt.low_done;
   assign any_up_w  = |i_evt.up_done;

   // activity indicators; completion wins over a same-cycle start
   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         scan_act_reg <= 1'b0;
         int_act_reg  <= 1'b0;
      end
      else
      begin
         // R10 scan done clears scan active
         if (i_evt.scan_done)
            scan_act_reg <= 1'b0;
         else if (i_scan_start)
            scan_act_reg <= 1'b1;
         // R11 channel done clears interrupt-conversion active
         if (any_low_w | any_up_w)
            int_act_reg <= 1'b0;
         else if (i_intconv_start)
            int_act_reg <= 1'b1;
      end
   end

   assign o_scan_active_indicator    = scan_act_reg;
   assign o_intconv_active_indicator = int_act_reg;

   // R12 cpu level follows flag and enable, changing on the same edge as the flag
   cpu_level_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R12
      o_scan_end_irq == (o_scan_end_flag & i_scan_end_irq_enable & ~i_scan_to_dma)
      || $changed(i_scan_end_irq_enable) || $changed(i_scan_to_dma))
      else $error("scan irq level mismatch");
   scan_gate_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R1
      !i_scan_end_irq_enable ##1 !i_scan_end_irq_enable |-> !o_scan_end_irq)
      else $error("scan irq while disabled");
   no_cpu_dma_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R2
      !(o_scan_end_irq && o_scan_dma_req))
      else $error("scan irq and dma together");
   scan_dmaclr_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R3
      i_scan_dma_ack && i_scan_to_dma && !i_evt.scan_done |=> !o_scan_end_flag)
      else $error("dma did not clear scan flag");
   scan_hold_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R4
      o_scan_end_flag && !i_sw_clr.scan && !(i_scan_dma_ack && i_scan_to_dma)
      |=> o_scan_end_flag)
      else $error("scan flag lost without clear");
   chan_set_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R5
      i_evt.low_done[1] |=> o_chan_conv_end_flag[1])
      else $error("channel flag not set");
   chan_en_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R6
      !i_upper_chan_conv_end_irq_enable[0] ##1 !i_upper_chan_conv_end_irq_enable[0]
      |-> !o_upper_chan_conv_end_irq[0])
      else $error("upper irq while disabled");
   up_dmaclr_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R7
      i_up_dma_ack[0] && i_up_to_dma[0] && !i_evt.up_done[0]
      |=> !o_upper_chan_conv_end_flag[0])
      else $error("dma did not clear upper flag");
   ch0_dmaclr_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R8
      i_chan0_dma_ack && i_chan0_to_dma && !i_evt.low_done[0]
      |=> !o_chan_conv_end_flag[0])
      else $error("second dma did not clear channel 0");
   chan_hold_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R9
      o_chan_conv_end_irq[2] && !i_sw_clr.low[2] |=> o_chan_conv_end_flag[2])
      else $error("cpu request cleared channel flag");
   scan_done_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R10
      i_evt.scan_done |=> o_scan_end_flag && !o_scan_active_indicator)
      else $error("scan completion wrong");
   int_done_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R11
      i_evt.up_done[3] |=> o_upper_chan_conv_end_flag[3] && !o_intconv_active_indicator)
      else $error("interrupt completion wrong");

   // scan completion that should reach the cpu: enabled and not routed
   sequence scan_done_cpu_s;
      i_evt.scan_done && i_scan_end_irq_enable && !i_scan_to_dma;
   endsequence
   // software clear of the scan flag with no new completion beside it
   sequence scan_swclr_s;
      i_sw_clr.scan && !i_evt.scan_done;
   endsequence

   // R1 R12 completion raises flag and cpu request together
   scan_raise_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R12
      scan_done_cpu_s |=> o_scan_end_flag && o_scan_end_irq)
      else $error("scan request did not rise with flag");
   // R12 software clear drops flag and request on one edge
   scan_drop_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R12
      scan_done_cpu_s ##1 scan_swclr_s |=> !o_scan_end_flag && !o_scan_end_irq)
      else $error("scan request stayed after clear");
   // R2 a routed scan-end never reaches the cpu
   scan_route_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R2
      i_scan_to_dma |=> !o_scan_end_irq)
      else $error("routed scan end reached cpu");
   // R12 lower channel level follows flag and enable
   chan_level_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R12
      o_chan_conv_end_flag[5] && i_chan_conv_end_irq_enable[5] && !i_sw_clr.low[5]
      |=> o_chan_conv_end_irq[5])
      else $error("channel request missing");
   // R6 R12 dropping the enable withdraws the request
   chan_mask_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R6
      !i_chan_conv_end_irq_enable[5] |=> !o_chan_conv_end_irq[5])
      else $error("channel request while disabled");
endmodule

// ---- tb/adccev_dma_model.sv ----
// dma controller model answering the block's transfer requests
// assumes requests are levels and an ack is read at the next rising edge
module adccev_dma_model
(
   input  wire logic       i_clock,  // peripheral clock
   input  wire logic [9:0] i_req,    // {scan, chan0, upper} requests
   input  wire logic       i_slow,   // 1: answer after random waits
   output logic      [9:0] o_ack     // one-cycle transfer pulses
);
   timeunit 1ns;
   timeprecision 1ns;
   // one pulse per look; never two back to back, so the flag can drop first
   // requests are low through reset, so the first falling edge clears the ack
   always @(negedge i_clock)
   begin
      for (int i = 0; i < 10; i++)
      begin
         o_ack[i] <= i_req[i] & ~o_ack[i] & (~i_slow | ($urandom_range(0, 3) == 0));
      end
   end
endmodule

// ---- tb/adccev_top_test.sv ----
// self-checking bench for the completion-event block
// assumes the dma model is compiled first; flags kept as {scan, low, up}
module adccev_top_test
   import adccev_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clock;             // bench clock
   logic        i_rstn;              // reset, active low
   adccev_evt_t evt;                 // completion pulses
   adccev_clr_t clr;                 // software clears
   logic        s_go, i_go;          // indicator starts
   logic [24:0] en;                  // enables
   logic [9:0]  rt;                  // {scan, chan0, up} dma routes
   logic        slow;                // dma model pace
   logic [9:0]  ack;                 // dma transfers done
   logic [24:0] flg, irq;            // seen flags and cpu requests
   logic [9:0]  dma;                 // seen dma requests
   logic        s_act, i_act;        // seen indicators
   logic [24:0] e_flg, e_irq;        // expected flags and requests
   logic [9:0]  e_dma;               // expected dma requests
   logic        e_s, e_i;            // expected indicators
   int          fail_count = 0;      // mismatches
   int          cmp_count = 0;       // comparisons
   adccev_top dut
   (
      .i_clock(i_clock), .i_rstn(i_rstn), .i_evt(evt), .i_scan_start(s_go),
      .i_intconv_start(i_go), .i_sw_clr(clr), .i_scan_end_irq_enable(en[24]),
      .i_chan_conv_end_irq_enable(en[23:8]), .i_upper_chan_conv_end_irq_enable(en[7:0]),
      .i_scan_to_dma(rt[9]), .i_up_to_dma(rt[7:0]), .i_chan0_to_dma(rt[8]),
      .i_scan_dma_ack(ack[9]), .i_up_dma_ack(ack[7:0]), .i_chan0_dma_ack(ack[8]),
      .o_scan_end_flag(flg[24]), .o_chan_conv_end_flag(flg[23:8]),
      .o_upper_chan_conv_end_flag(flg[7:0]), .o_scan_end_irq(irq[24]),
      .o_chan_conv_end_irq(irq[23:8]), .o_upper_chan_conv_end_irq(irq[7:0]),
      .o_scan_dma_req(dma[9]), .o_up_dma_req(dma[7:0]), .o_chan0_dma_req(dma[8]),
      .o_scan_active_indicator(s_act), .o_intconv_active_indicator(i_act)
   );
   adccev_dma_model dma_side
   (
      .i_clock(i_clock), .i_req(dma), .i_slow(slow), .o_ack(ack)
   );
   // lower channels 1..15 have no dma path, so their route and ack stay 0
   function automatic logic [24:0] wide(input logic [9:0] v);
      return {v[9], 15'h0000, v[8], v[7:0]};
   endfunction
   // set wins over a clear in the same cycle
   function automatic logic [24:0] nxt(input logic [24:0] f, s, c, a, r);
      return s | (f & ~c & ~(a & r));
   endfunction
   // reference registers, updated on the same edge as the block
   always @(posedge i_clock or negedge i_rstn)
   begin
      logic [24:0] fn;
      fn = nxt(e_flg, evt, clr, wide(ack), wide(rt));
      if (!i_rstn)
      begin
         e_flg <= '0;
         e_irq <= '0;
         e_dma <= '0;
         e_s <= 1'b0;
         e_i <= 1'b0;
      end
      else
      begin
         e_flg <= fn;
         e_irq <= fn & en & ~wide(rt);
         e_dma <= {fn[24] & en[24] & rt[9], fn[8] & en[8] & rt[8], fn[7:0] & en[7:0] & rt[7:0]};
         e_s <= ~evt.scan_done & (e_s | s_go);
         e_i <= ~(|evt.low_done | |evt.up_done) & (e_i | i_go);
      end
   end
   task automatic check(input logic [24:0] seen, exp, input string what);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %0t %s", $time, what);
      end
   endtask
   task automatic close_out();
      if (fail_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // compare at the falling edge, then drive the next cycle's inputs
   task automatic step(input logic [24:0] ev, cl);
      @(negedge i_clock);
      check(flg, e_flg, "flags");
      check(irq, e_irq, "cpu requests");
      check(dma, e_dma, "dma requests");
      check({s_act, i_act}, {e_s, e_i}, "active");
      evt = ev;
      clr = cl;
      s_go = ($urandom_range(0, 7) == 0);
      i_go = ($urandom_range(0, 7) == 0);
   endtask
   initial
   begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end
   // about 3000 cycles are needed; give a third more
   initial
   begin
      #400000;
      fail_count++;
      close_out();
   end
   initial
   begin
      i_rstn = 1'b0;
      evt = '0;
      clr = '0;
      s_go = 1'b0;
      i_go = 1'b0;
      en = '1;
      rt = '0;
      slow = 1'b0;
      void'($urandom(50853));
      repeat (3) @(posedge i_clock);
      @(negedge i_clock) i_rstn = 1'b1;
      step('1, '1);
      step('0, '0);
      for (int n = 0; n < 3000; n++)
      begin
         if (n % 150 == 0)
         begin
            en = 25'($urandom);
            rt = 10'($urandom);
            slow = 1'($urandom);
         end
         step(25'($urandom & $urandom & $urandom), 25'($urandom & $urandom & $urandom & $urandom));
      end
      // reset in mid-run with flags pending
      i_rstn = 1'b0;
      step('0, '0);
      i_rstn = 1'b1;
      step('1, '0);
      step('0, '0);
      close_out();
   end
endmodule
